// *** hw/ombps_top.sv ***
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module ombps_top
	import ombps_pkg::*;
#(
	parameter int SW = 2
) (
	input  wire logic        mclk,              // 200 MHz bus clock
	input  wire logic        rst_n,             // async reset, active low
	input  wire logic        psel,              // apb select
	input  wire logic        penable,           // apb enable
	input  wire logic        pwrite,            // apb direction
	input  wire logic [11:0] paddr,             // apb byte address
	input  wire logic [31:0] pwdata,            // apb write data
	output logic      [31:0] prdata,            // apb read data
	output logic             pready,            // apb ready
	output logic             pslverr,           // apb error, unmapped
	input  wire logic        mode_select_high,  // mode pin
	input  wire logic        mode_select_middle, // mode pin, shared with bit 6
	input  wire logic        mode_select_low,   // mode pin, shared with bit 5
	input  wire logic [7:0]  pa_in,             // port a pin level
	output logic      [7:0]  pa_out,            // port a drive value
	output logic      [7:0]  pa_oe,             // port a drive enable
	output logic             pa_pull_en,        // port a pulls
	input  wire logic [7:0]  pb_in,             // port b pin level
	output logic      [7:0]  pb_out,            // port b drive value
	output logic      [7:0]  pb_oe,             // port b drive enable
	output logic             pb_pull_en,        // port b pulls
	input  wire logic [7:0]  pe_in,             // control port pin level
	output logic      [7:0]  pe_out,            // control port drive value
	output logic      [7:0]  pe_oe,             // control port drive enable
	output logic      [7:0]  pe_pull_en,        // control port pulls
	input  wire logic        ext_req,           // external access request
	input  wire logic        ext_write,         // access is a write
	input  wire logic        ext_low_byte,      // low byte strobe asserted
	input  wire logic [15:0] ext_addr,          // access address
	input  wire logic [15:0] ext_wdata,         // access write data
	output logic             ext_ack,           // access done pulse
	output logic      [15:0] ext_rdata,         // access read data
	input  wire logic        pipe_status_hi,    // cpu pipe status
	input  wire logic        pipe_status_lo,    // cpu pipe status
	input  wire logic        debug_cmd,         // serial activate pulse
	input  wire logic        irq_enable,        // cpu maskable enable
	input  wire logic        nmi_enable,        // cpu nonmaskable enable
	output logic             debug_active,      // debug in control
	output logic      [2:0]  mode_code,         // current mode
	output logic             irq_req_n,         // maskable request
	output logic             nmi_req_n          // nonmaskable request
);
	logic                  capt_q;
	logic [2:0]            mode_q;
	logic                  internal_visibility_q;
	logic                  once_q;
	logic                  dbg_q;
	logic                  pipe_en_q;
	logic                  bus_e_clock_dis_q;
	logic                  low_byte_strobe_en_q;
	logic                  rw_en_q;
	logic                  stretch_en_q;
	logic [SW-1:0]         stretch_q;
	logic [7:0]            pa_dat_q;
	logic [7:0]            pa_dir_q;
	logic [7:0]            pb_dat_q;
	logic [7:0]            pb_dir_q;
	logic [7:0]            pe_dat_q;
	logic [7:0]            pe_dir_q;
	logic [2:0]            pull_q;
	ombps_bus_t            bus_q;
	logic [SW-1:0]         cnt_q;
	logic                  acc_wr_q;
	logic                  acc_lb_q;
	logic [15:0]           acc_addr_q;
	logic [15:0]           acc_wdata_q;
	logic                  bus_e_clock_q;
	logic                  fin_q;
	logic [7:0]            pa_out_d, pa_oe_d, pb_out_d, pb_oe_d;
	logic [7:0]            pe_out_d, pe_oe_d;

	function automatic logic is_special(input logic [2:0] m);
		return ~m[2];
	endfunction : is_special

	function automatic logic is_single(input logic [2:0] m);
		return (m == MD_SPC_SINGLE) || (m == MD_NRM_SINGLE);
	endfunction : is_single

	function automatic logic is_emu(input logic [2:0] m);
		return (m == MD_EMU_NARROW) || (m == MD_EMU_WIDE);
	endfunction : is_emu

	function automatic logic is_narrow(input logic [2:0] m);
		return (m == MD_EMU_NARROW) || (m == MD_NRM_NARROW);
	endfunction : is_narrow

	function automatic logic is_expanded(input logic [2:0] m);
		return !is_single(m) && (m != MD_PERIPH);
	endfunction : is_expanded

	logic wr_acc;
	logic setup;
	logic expanded;
	logic emu;
	logic [2:0] new_mode;
	logic mode_wr_ok;
	logic free_bus_e_clock;

	assign setup      = psel && !penable;
	assign wr_acc     = psel && penable && pwrite && pready;
	assign expanded   = is_expanded(mode_q);
	assign emu        = is_emu(mode_q);
	assign new_mode   = pwdata[MODE_LSB+2:MODE_LSB];
	// special modes write freely; normal single chip once; others locked
	assign mode_wr_ok = is_special(mode_q) ? 1'b1 : (mode_q == MD_NRM_SINGLE) && !once_q; // RL4 RL13

	// mode capture on the first edge after reset release
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			capt_q <= 1'b0;
			mode_q <= MD_NRM_SINGLE;
			internal_visibility_q <= 1'b0;
			once_q <= 1'b0;
		end else if (!capt_q) begin
			capt_q <= 1'b1;
			mode_q <= {mode_select_high, mode_select_middle, mode_select_low}; // RL1 RL2
		end else if (wr_acc && paddr == OFS_MODE && mode_wr_ok) begin
			once_q <= 1'b1; // RL13
			internal_visibility_q <= pwdata[MODE_INTERNAL_VISIBILITY] && !is_narrow(new_mode);
			// peripheral mode is reached only through reset
			if (new_mode != MD_PERIPH && (is_special(mode_q) || new_mode[2])) begin
				mode_q <= new_mode; // RL4
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dbg_q <= 1'b0;
		end else if (!capt_q) begin
			dbg_q <= ({mode_select_high, mode_select_middle, mode_select_low} == MD_SPC_SINGLE); // RL5
		end else if (debug_cmd) begin
			dbg_q <= 1'b1; // RL5
		end
	end

	// port assignment bits; emulation modes refuse writes
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pipe_en_q  <= 1'b0;
			bus_e_clock_dis_q <= 1'b0;
			low_byte_strobe_en_q <= 1'b0;
			rw_en_q    <= 1'b0;
		end else if (!capt_q) begin
			pipe_en_q  <= 1'b0; // RL12
			low_byte_strobe_en_q <= 1'b0; // RL12
			rw_en_q    <= 1'b0; // RL12
			bus_e_clock_dis_q <= ({mode_select_high, mode_select_middle, mode_select_low}
			              == MD_NRM_SINGLE); // RL14 RL21
		end else if (wr_acc && paddr == OFS_PORT_ASSIGN && !emu) begin
			pipe_en_q  <= pwdata[PA_PIPE];
			bus_e_clock_dis_q <= pwdata[PA_BUS_E_CLOCK_DIS];
			low_byte_strobe_en_q <= pwdata[PA_LOW_BYTE_STROBE];
			rw_en_q    <= pwdata[PA_RW];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stretch_en_q <= 1'b1; // RL8
			stretch_q    <= SW'(STRETCH_RST);
		end else begin
			if (wr_acc && paddr == OFS_BUS_CTRL) begin
				stretch_en_q <= pwdata[BC_STRETCH];
			end
			if (wr_acc && paddr == OFS_STRETCH) begin
				stretch_q <= pwdata[SW-1:0]; // RL22
			end
		end
	end

	// general purpose port data, direction and pulls
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pa_dat_q <= 8'h00;
			pa_dir_q <= 8'h00; // RL11
			pb_dat_q <= 8'h00;
			pb_dir_q <= 8'h00; // RL11
			pe_dat_q <= 8'h00;
			pe_dir_q <= 8'h00; // RL11
			pull_q   <= PULL_RST; // RL11
		end else if (wr_acc) begin
			unique case (paddr)
				OFS_PA_DATA: pa_dat_q <= pwdata[7:0];
				OFS_PA_DIR:  pa_dir_q <= pwdata[7:0];
				OFS_PB_DATA: pb_dat_q <= pwdata[7:0];
				OFS_PB_DIR:  pb_dir_q <= pwdata[7:0];
				OFS_PE_DATA: pe_dat_q <= pwdata[7:0];
				OFS_PE_DIR:  pe_dir_q <= pwdata[7:0] & ~PE_INPUT_ONLY; // RL6 RL7
				OFS_PULL:    pull_q   <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// apb slave: one access cycle, read data staged in setup
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= 1'b0;
			if (setup) begin
				prdata <= 32'h0000_0000;
				unique case (paddr)
					OFS_MODE: begin
						prdata[MODE_LSB+2:MODE_LSB] <= mode_q;
						prdata[MODE_INTERNAL_VISIBILITY]           <= internal_visibility_q;
					end
					OFS_PORT_ASSIGN: begin
						prdata[PA_PIPE]     <= pipe_en_q;
						prdata[PA_BUS_E_CLOCK_DIS] <= bus_e_clock_dis_q;
						prdata[PA_LOW_BYTE_STROBE]    <= low_byte_strobe_en_q;
						prdata[PA_RW]       <= rw_en_q;
					end
					OFS_BUS_CTRL: prdata[BC_STRETCH] <= stretch_en_q;
					OFS_STRETCH:  prdata[SW-1:0] <= stretch_q;
					OFS_STATUS: begin
						prdata[ST_DBG]                  <= dbg_q;
						prdata[ST_ONCE]                 <= once_q;
						prdata[ST_MODE_LSB+2:ST_MODE_LSB] <= mode_q;
					end
					OFS_PA_DATA: prdata[7:0] <= pa_dat_q;
					OFS_PA_DIR:  prdata[7:0] <= pa_dir_q;
					OFS_PB_DATA: prdata[7:0] <= pb_dat_q;
					OFS_PB_DIR:  prdata[7:0] <= pb_dir_q;
					OFS_PE_DATA: prdata[7:0] <= pe_dat_q;
					OFS_PE_DIR:  prdata[7:0] <= pe_dir_q;
					OFS_PULL:    prdata[2:0] <= pull_q;
					default:     pslverr <= 1'b1;
				endcase
			end
		end
	end

	// external access sequencer: address phase, then stretched data phase
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus_q       <= OMB_IDLE;
			cnt_q       <= '0;
			acc_wr_q    <= 1'b0;
			acc_lb_q    <= 1'b0;
			acc_addr_q  <= 16'h0000;
			acc_wdata_q <= 16'h0000;
			fin_q       <= 1'b0;
			ext_ack     <= 1'b0;
			ext_rdata   <= 16'h0000;
		end else begin
			ext_ack <= 1'b0;
			fin_q   <= 1'b0;
			// pins lag the state by one cycle, so read data stands on them only now
			if (fin_q) begin
				ext_ack   <= 1'b1;
				ext_rdata <= is_narrow(mode_q) ? {8'h00, pa_in} : {pa_in, pb_in}; // RL22
			end
			unique case (bus_q)
				OMB_IDLE: begin
					if (ext_req && capt_q && !ext_ack && !fin_q) begin
						acc_wr_q    <= ext_write;
						acc_lb_q    <= ext_low_byte;
						acc_addr_q  <= ext_addr;
						acc_wdata_q <= ext_wdata;
						if (expanded) begin
							bus_q <= OMB_ADDR; // RL15
						end else begin
							ext_ack   <= 1'b1; // RL10
							ext_rdata <= 16'h0000;
						end
					end
				end
				OMB_ADDR: begin
					bus_q <= OMB_DATA; // RL22
					cnt_q <= stretch_q;
				end
				OMB_DATA: begin
					if (cnt_q == '0) begin
						bus_q <= OMB_IDLE;
						fin_q <= 1'b1;
					end else begin
						cnt_q <= cnt_q - SW'(1); // RL22
					end
				end
			endcase
		end
	end

	// E clock tracks the bus during accesses; when idle it runs free only with stretch off, visibility set or single chip, else low
	assign free_bus_e_clock = !stretch_en_q || internal_visibility_q || is_single(mode_q); // RL21 RL14

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bus_e_clock_q <= 1'b0;
		end else if (bus_q != OMB_IDLE) begin
			bus_e_clock_q <= (bus_q == OMB_ADDR) || (bus_q == OMB_DATA && cnt_q != '0); // RL22
		end else if (free_bus_e_clock) begin
			bus_e_clock_q <= !bus_e_clock_q;
		end else begin
			bus_e_clock_q <= 1'b0;
		end
	end

	always_comb begin
		pa_out_d = pa_dat_q;
		pa_oe_d  = pa_dir_q;
		pb_out_d = pb_dat_q;
		pb_oe_d  = pb_dir_q;
		pe_out_d = pe_dat_q;
		pe_oe_d  = pe_dir_q & ~PE_INPUT_ONLY; // RL6 RL7 RL10
		if (expanded) begin
			pa_oe_d  = 8'hFF; // RL15
			pb_oe_d  = 8'hFF;
			pa_out_d = acc_addr_q[15:8];
			pb_out_d = acc_addr_q[7:0];
			if (bus_q == OMB_DATA) begin
				pa_oe_d  = acc_wr_q ? 8'hFF : 8'h00;
				pa_out_d = acc_wdata_q[15:8];
				if (!is_narrow(mode_q)) begin
					pb_oe_d  = acc_wr_q ? 8'hFF : 8'h00;
					pb_out_d = acc_wdata_q[7:0];
				end else begin
					pa_out_d = acc_wdata_q[7:0];
				end
			end
			if (pipe_en_q) begin
				pe_oe_d[PE_PIPE_HI]  = 1'b1; // RL17
				pe_oe_d[PE_PIPE_LO]  = 1'b1;
				pe_out_d[PE_PIPE_HI] = pipe_status_hi;
				pe_out_d[PE_PIPE_LO] = pipe_status_lo;
			end
			if (low_byte_strobe_en_q && !is_narrow(mode_q)) begin
				pe_oe_d[PE_LOW_BYTE_STROBE]  = 1'b1; // RL20
				pe_out_d[PE_LOW_BYTE_STROBE] = !(bus_q != OMB_IDLE && acc_lb_q);
			end
			if (rw_en_q) begin
				pe_oe_d[PE_RW]  = 1'b1; // RL18
				pe_out_d[PE_RW] = !(bus_q != OMB_IDLE && acc_wr_q);
			end
		end
		if (!bus_e_clock_dis_q && mode_q != MD_PERIPH) begin
			pe_oe_d[PE_BUS_E_CLOCK]  = 1'b1; // RL14 RL16 RL21
			pe_out_d[PE_BUS_E_CLOCK] = bus_e_clock_q;
		end
	end

	// pin drivers; all inputs with no drive until the mode is captured
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pa_out     <= 8'h00;
			pa_oe      <= 8'h00;
			pb_out     <= 8'h00;
			pb_oe      <= 8'h00;
			pe_out     <= 8'h00;
			pe_oe      <= 8'h00; // RL9
			pa_pull_en <= 1'b0;
			pb_pull_en <= 1'b0;
			pe_pull_en <= 8'h00; // RL9
		end else if (capt_q) begin
			pa_out     <= pa_out_d;
			pa_oe      <= pa_oe_d;
			pb_out     <= pb_out_d;
			pb_oe      <= pb_oe_d;
			pe_out     <= pe_out_d;
			pe_oe      <= pe_oe_d;
			pa_pull_en <= pull_q[PU_A] && !expanded; // RL11
			pb_pull_en <= pull_q[PU_B] && !expanded;
			pe_pull_en <= {8{pull_q[PU_E]}} & ~pe_oe_d | PE_INPUT_ONLY; // RL6 RL7 RL11
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			debug_active <= 1'b0;
			mode_code    <= MD_NRM_SINGLE;
			irq_req_n    <= 1'b1;
			nmi_req_n    <= 1'b1;
		end else begin
			debug_active <= dbg_q;
			mode_code    <= mode_q;
			irq_req_n    <= !(irq_enable && !pe_in[PE_IRQ]); // RL6
			nmi_req_n    <= !(nmi_enable && !pe_in[PE_NMI]); // RL7
		end
	end
endmodule : ombps_top

// *** inc/ombps_pkg.sv ***
// Summary of operation
// RL1: mode pins latched at reset release
// RL2: decode eight operating modes from pins
// RL3: never select peripheral mode with debug
// RL4: normal modes protect controls, special allow
// RL5: debug active after reset only special-single
// RL6: control bit1 pulled-up input, interrupt inhibited
// RL7: control bit0 pulled-up input, nmi inhibited
// RL8: reset sets stretch enable in all modes
// RL9: mode pins high-impedance during reset
// RL10: single chip: no bus, all general I/O
// RL11: single chip pin pulls and directions
// RL12: single chip overrides pipe, strobe, r/w bits
// RL13: single chip mode register writable once
// RL14: single chip E clock when disable cleared
// RL15: wide modes: multiplexed bus, E clock
// RL16: wide mode enable bits claim control pins
// RL17: pipe enable drives pipe status bits 6,5
// RL18: r/w enable drives control bit 2
// RL19: software enables r/w before external writes
// RL20: strobe enable drives control bit 3
// RL21: E clock follows disable, visibility, stretch
// RL22: stretch data phase 0-3 cycles only
package ombps_pkg;
	localparam logic [2:0]  MD_SPC_SINGLE  = 3'h0;
	localparam logic [2:0]  MD_EMU_NARROW  = 3'h1;
	localparam logic [2:0]  MD_SPC_TEST    = 3'h2;
	localparam logic [2:0]  MD_EMU_WIDE    = 3'h3;
	localparam logic [2:0]  MD_NRM_SINGLE  = 3'h4;
	localparam logic [2:0]  MD_NRM_NARROW  = 3'h5;
	localparam logic [2:0]  MD_PERIPH      = 3'h6;
	localparam logic [2:0]  MD_NRM_WIDE    = 3'h7;

	localparam logic [11:0] OFS_MODE       = 12'h000;
	localparam logic [11:0] OFS_PORT_ASSIGN = 12'h004;
	localparam logic [11:0] OFS_BUS_CTRL   = 12'h008;
	localparam logic [11:0] OFS_STRETCH    = 12'h00C;
	localparam logic [11:0] OFS_STATUS     = 12'h010;
	localparam logic [11:0] OFS_PA_DATA    = 12'h014;
	localparam logic [11:0] OFS_PA_DIR     = 12'h018;
	localparam logic [11:0] OFS_PB_DATA    = 12'h01C;
	localparam logic [11:0] OFS_PB_DIR     = 12'h020;
	localparam logic [11:0] OFS_PE_DATA    = 12'h024;
	localparam logic [11:0] OFS_PE_DIR     = 12'h028;
	localparam logic [11:0] OFS_PULL       = 12'h02C;

	localparam int MODE_LSB     = 5;
	localparam int MODE_INTERNAL_VISIBILITY    = 3;
	localparam int PA_PIPE      = 5;
	localparam int PA_BUS_E_CLOCK_DIS  = 4;
	localparam int PA_LOW_BYTE_STROBE     = 3;
	localparam int PA_RW        = 2;
	localparam int BC_STRETCH   = 0;
	localparam int ST_DBG       = 0;
	localparam int ST_ONCE      = 1;
	localparam int ST_MODE_LSB  = 2;
	localparam int PU_A         = 0;
	localparam int PU_B         = 1;
	localparam int PU_E         = 2;

	localparam int PE_PIPE_HI   = 6;
	localparam int PE_PIPE_LO   = 5;
	localparam int PE_BUS_E_CLOCK      = 4;
	localparam int PE_LOW_BYTE_STROBE     = 3;
	localparam int PE_RW        = 2;
	localparam int PE_IRQ       = 1;
	localparam int PE_NMI       = 0;

	localparam logic [2:0]  PULL_RST       = 3'h4;
	localparam logic [7:0]  PE_INPUT_ONLY  = 8'h03;
	localparam logic [1:0]  STRETCH_RST    = 2'h3;

	typedef enum logic [1:0] {OMB_IDLE, OMB_ADDR, OMB_DATA} ombps_bus_t;
endpackage : ombps_pkg

// *** tb/ombps_checker.sv ***
`timescale 1ns/1ps
module ombps_checker
	import ombps_pkg::*;
#(
	parameter int SW = 2
) (
	input wire logic        mclk,               // clock
	input wire logic        rst_n,              // reset
	input wire logic        psel,               // apb
	input wire logic        penable,            // apb
	input wire logic        pready,             // apb
	input wire logic        pslverr,            // apb
	input wire logic        mode_select_high,   // pin
	input wire logic        mode_select_middle, // pin
	input wire logic        mode_select_low,    // pin
	input wire logic [7:0]  pa_out,             // port a
	input wire logic [7:0]  pa_oe,              // port a
	input wire logic [7:0]  pb_out,             // port b
	input wire logic [7:0]  pe_in,              // port e
	input wire logic [7:0]  pe_oe,              // port e
	input wire logic        ext_req,            // bus
	input wire logic [15:0] ext_addr,           // bus
	input wire logic        ext_ack,            // bus
	input wire logic [15:0] ext_rdata,          // bus
	input wire logic        debug_cmd,          // debug
	input wire logic        debug_active,       // debug
	input wire logic        irq_enable,         // irq
	input wire logic        nmi_enable,         // nmi
	input wire logic        irq_req_n,          // irq
	input wire logic        nmi_req_n,          // nmi
	input wire logic [2:0]  mode_code           // mode
);
	logic [2:0] pins;
	assign pins = {mode_select_high, mode_select_middle, mode_select_low};
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence take_s;
		$rose(ext_req) && !ext_ack && mode_code == MD_NRM_WIDE;
	endsequence
	sequence addr_s;
		pa_oe == 8'hFF && {pa_out, pb_out} == $past(ext_addr, 2);
	endsequence
	apb_ready_a: assert property (psel && !penable |=> pready)
		else $error("ready missing after setup");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	mode_latch_a: assert property ($rose(rst_n) |-> ##2 mode_code == $past(pins, 2))
		else $error("mode pins not latched");
	debug_start_a: assert property ($rose(rst_n) |-> ##2 debug_active == (mode_code == 3'h0))
		else $error("debug state wrong after reset");
	debug_cmd_a: assert property ($rose(debug_active) && mode_code != 3'h0 |-> $past(debug_cmd, 2))
		else $error("debug active without command");
	irq_follow_a: assert property (irq_req_n == !($past(irq_enable) && !$past(pe_in[PE_IRQ])))
		else $error("maskable request wrong");
	nmi_follow_a: assert property (nmi_req_n == !($past(nmi_enable) && !$past(pe_in[PE_NMI])))
		else $error("nonmaskable request wrong");
	input_only_a: assert property (pe_oe[1:0] == 2'h0)
		else $error("interrupt pins driven");
	reset_float_a: assert property (disable iff (1'b0) !rst_n |-> pe_oe[6:5] == 2'h0)
		else $error("mode pins driven in reset");
	single_ack_a: assert property (mode_code[1:0] == 2'h0 && ext_req && !ext_ack |=> ext_ack && ext_rdata == 16'h0)
		else $error("single chip access not answered empty");
	wide_addr_a: assert property (take_s |-> ##2 addr_s)
		else $error("address not on wide bus");
	wide_ack_a: assert property (take_s |=> (!ext_ack)[*3] ##[1:4] ext_ack)
		else $error("access length out of range");
endmodule : ombps_checker

bind ombps_top ombps_checker #(.SW(SW)) chk (.*);

// *** tb/ombps_ext_mem.sv ***
`timescale 1ns/1ps
module ombps_ext_mem
	import ombps_pkg::*;
(
	input  wire logic       mclk,       // clock
	input  wire logic [7:0] pa_out,     // port a drive
	input  wire logic [7:0] pa_oe,      // port a enable
	input  wire logic       pa_pull_en, // port a pulls
	input  wire logic [7:0] pb_out,     // port b drive
	input  wire logic [7:0] pb_oe,      // port b enable
	input  wire logic       pb_pull_en, // port b pulls
	input  wire logic [7:0] pe_out,     // control drive
	input  wire logic [7:0] pe_oe,      // control enable
	output logic      [7:0] pa_in,      // port a level
	output logic      [7:0] pb_in       // port b level
);
	logic [15:0] mem [0:255];
	logic [15:0] addr_q;
	logic [15:0] drv;
	logic        have_q;
	logic        bus_e_clock;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 16'(i * 16'h0101) ^ 16'h5A3C;
		end
		have_q = 1'b0;
		addr_q = 16'h0000;
	end
	assign bus_e_clock = pe_oe[PE_BUS_E_CLOCK] && pe_out[PE_BUS_E_CLOCK];
	// address phase while E is low, write data while E is high and rw low
	always @(posedge mclk) begin
		if (pa_oe == 8'hFF && pb_oe == 8'hFF && !bus_e_clock) begin
			addr_q <= {pa_out, pb_out};
			have_q <= 1'b1;
		end
		if (pa_oe == 8'hFF && bus_e_clock && pe_oe[PE_RW] && !pe_out[PE_RW]) begin
			mem[addr_q[7:0]] <= {pa_out, pb_out};
		end
	end
	// released lines float to pull level, the word at the latched address, or before any address the inverse of the drive
	assign drv = have_q ? mem[addr_q[7:0]] : ~{pa_out, pb_out};
	assign pa_in = (pa_oe & pa_out) | (~pa_oe & (pa_pull_en ? 8'hFF : drv[15:8]));
	assign pb_in = (pb_oe & pb_out) | (~pb_oe & (pb_pull_en ? 8'hFF : drv[7:0]));
endmodule : ombps_ext_mem

// *** tb/operating_mode_and_bus_pin_setup_tb.sv ***
`timescale 1ns/1ps
module operating_mode_and_bus_pin_setup_tb
	import ombps_pkg::*;
;
	logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        mode_select_high, mode_select_middle, mode_select_low;
	logic [7:0]  pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe, pe_in, pe_out, pe_oe, pe_pull_en;
	logic        pa_pull_en, pb_pull_en, ext_req, ext_write, ext_low_byte, ext_ack;
	logic [15:0] ext_addr, ext_wdata, ext_rdata, a, d;
	logic        pipe_status_hi, pipe_status_lo, debug_cmd, debug_active;
	logic        irq_enable, nmi_enable, irq_req_n, nmi_req_n;
	logic [2:0]  mode_code;
	logic [7:0]  pe_drv;
	logic [32:0] apb_q[$];
	logic [15:0] ext_q[$];
	int          miscompares, checks_done, n, chg;

	ombps_top #(.SW(2)) uut (.*);
	ombps_ext_mem mem_model (.*);
	assign pe_in = (pe_oe & pe_out) | (~pe_oe & pe_drv);

	initial mclk = 1'b0;
	always #2.5 mclk = ~mclk;

	task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (!pready);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb

	task automatic rd(input logic [11:0] ad, input logic [32:0] exp);
		apb_q.push_back(exp);
		apb(1'b0, ad, 32'h0);
	endtask : rd

	task automatic ext(input logic w, input logic [15:0] ad, input logic [15:0] wd);
		ext_req <= 1'b1;
		ext_write <= w;
		ext_addr <= ad;
		ext_wdata <= wd;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (!ext_ack);
		ext_req <= 1'b0;
		@(posedge mclk);
	endtask : ext

	task automatic start(input logic [2:0] m);
		@(posedge mclk);
		rst_n <= 1'b0;
		{irq_enable, nmi_enable} <= 2'h0;
		{mode_select_high, mode_select_middle, mode_select_low} <= m;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask : start

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up

	// answers are compared in the cycle they stand
	always @(posedge mclk) begin
		if (psel && penable && pready && !pwrite && apb_q.size() > 0) begin
			check("prdata", apb_q.pop_front(), {pslverr, prdata});
		end
		if (ext_ack && !ext_write && ext_q.size() > 0) begin
			check("ext_rdata", {17'h0, ext_q.pop_front()}, {17'h0, ext_rdata});
		end
	end

	initial begin
		#100us;
		miscompares++;
		$display("watchdog expired");
		wrap_up();
	end

	initial begin
		void'($urandom(32'h6277));
		{psel, penable, pwrite, ext_req, ext_write, ext_low_byte, debug_cmd} = '0;
		{irq_enable, nmi_enable, pipe_status_hi, pipe_status_lo} = '0;
		rst_n <= 1'b0;
		{paddr, pwdata, ext_addr, ext_wdata} = '0;
		{mode_select_high, mode_select_middle, mode_select_low} = MD_NRM_SINGLE;
		pe_drv = 8'hFF;
		for (int m = 0; m < 8; m++) begin
			if (m == 6) begin
				continue;
			end
			start(3'(m));
			check("mode_code", 33'(m), {30'h0, mode_code});
			check("debug_active", 33'(m == 0), {32'h0, debug_active});
			check("pe pulls 1:0", 33'h3, {31'h0, pe_pull_en[1:0]});
			rd(OFS_STATUS, 33'(m << 2 | (m == 0)));
			rd(OFS_BUS_CTRL, 33'h1);
			$display("test reset mode %0d done", m);
		end
		start(MD_NRM_SINGLE);
		check("ab drive", 33'h0, {17'h0, pa_oe, pb_oe});
		check("ab pulls", 33'h0, {31'h0, pa_pull_en, pb_pull_en});
		check("pe_oe", 33'h0, {25'h0, pe_oe});
		check("pe pulls", 33'hFF, {25'h0, pe_pull_en});
		rd(OFS_PORT_ASSIGN, 33'h10);
		apb(1'b1, OFS_PORT_ASSIGN, 32'h2C);
		{pipe_status_hi, pipe_status_lo} <= 2'($urandom);
		repeat (2) @(posedge mclk);
		check("pe_oe", 33'h10, {25'h0, pe_oe});
		rd(OFS_PORT_ASSIGN, 33'h2C);
		chg = 0;
		n = int'(pe_out[PE_BUS_E_CLOCK]);
		repeat (8) begin
			@(posedge mclk);
			chg += int'(pe_out[PE_BUS_E_CLOCK] !== n[0]);
			n = int'(pe_out[PE_BUS_E_CLOCK]);
		end
		check("bus_e_clock runs", 33'h8, 33'(chg));
		ext_q.push_back(16'h0);
		ext(1'b0, 16'h1234, 16'h0);
		check("single ack", 33'h2, 33'(n));
		debug_cmd <= 1'b1;
		@(posedge mclk);
		debug_cmd <= 1'b0;
		repeat (2) @(posedge mclk);
		check("debug_active", 33'h1, {32'h0, debug_active});
		apb(1'b1, OFS_MODE, 32'hE0);
		apb(1'b1, OFS_MODE, 32'h80);
		check("mode_code", 33'h7, {30'h0, mode_code});
		rd(OFS_STATUS, 33'h1F);
		$display("test single chip done");
		repeat (2) @(posedge mclk);
		check("pe_oe", 33'h7C, {25'h0, pe_oe});
		check("pipe pins", {31'h0, pipe_status_hi, pipe_status_lo}, {31'h0, pe_out[6:5]});
		for (int s = 0; s < 4; s++) begin
			a = {8'($urandom), 8'(s)};
			d = 16'($urandom);
			apb(1'b1, OFS_STRETCH, 32'(s));
			ext(1'b1, a, d);
			ext_q.push_back(d);
			ext(1'b0, a, 16'h0);
			check("ack delay", 33'(5 + s), 33'(n));
		end
		repeat (16) begin
			@(posedge mclk);
			{irq_enable, nmi_enable, pe_drv} <= 10'($urandom);
		end
		{irq_enable, nmi_enable, pe_drv} <= 10'h300;
		repeat (2) @(posedge mclk);
		check("irq nmi", 33'h0, {31'h0, irq_req_n, nmi_req_n});
		$display("test wide bus done");
		start(MD_NRM_WIDE);
		check("pe_oe", 33'h10, {25'h0, pe_oe});
		apb(1'b1, OFS_MODE, 32'h0);
		check("mode_code", 33'h7, {30'h0, mode_code});
		rd(12'h0FC, {1'b1, 32'h0});
		start(MD_SPC_TEST);
		apb(1'b1, OFS_MODE, 32'hE0);
		@(posedge mclk);
		check("mode_code", 33'h7, {30'h0, mode_code});
		$display("test protection done");
		wrap_up();
	end
endmodule : operating_mode_and_bus_pin_setup_tb
